// ### pkg/ptd_pkg.sv
// Package: constants, types and encodings for the pipeline timing and decode block
`default_nettype none
package ptd_pkg;
	localparam int PTD_CNT_W = 8;
	typedef logic [PTD_CNT_W-1:0] ptd_cnt_t;

	// Loader cycle figures
	localparam logic [1:0] PTD_LD_FIELD_CYC = 2'h1;
	localparam logic [1:0] PTD_LD_ODD_DW_EXTRA = 2'h1;
	localparam logic [1:0] PTD_LD_DFP_CYC = 2'h2;

	// Address unit cycle figures
	localparam ptd_cnt_t PTD_AU_BASE_CYC = 8'h02;
	localparam ptd_cnt_t PTD_AU_NONPIPE_CYC = 8'h03;
	localparam ptd_cnt_t PTD_AU_QUAD_MEM_CYC = 8'h02;
	localparam ptd_cnt_t PTD_AU_DUAL_MEM_CYC = 8'h02;
	localparam ptd_cnt_t PTD_AU_MEMREL_CYC = 8'h03;
	localparam ptd_cnt_t PTD_AU_EXT_CYC = 8'h08;
	localparam ptd_cnt_t PTD_AU_SCALED_CYC = 8'h02;

	// Interlock stall figures
	localparam ptd_cnt_t PTD_BASE_STALL_N1 = 8'h03;
	localparam ptd_cnt_t PTD_BASE_STALL_N2 = 8'h01;
	localparam ptd_cnt_t PTD_IDX_STALL_N1 = 8'h01;
	localparam ptd_cnt_t PTD_WIDE_SRC_STALL = 8'h02;

	// Memory-management format operation codes
	localparam logic [3:0] PTD_READ_VALIDATE_OP = 4'h0;
	localparam logic [3:0] PTD_WRITE_VALIDATE_OP = 4'h1;
	localparam logic [3:0] PTD_LOAD_MGMT_REG_OP = 4'h2;
	localparam logic [3:0] PTD_STORE_MGMT_REG_OP = 4'h3;
	localparam logic [3:0] PTD_CACHE_INVALIDATE_OP = 4'h9;

	// Custom-slave sub-formats and sub-format zero codes
	localparam logic [2:0] PTD_CUST_SUB0 = 3'h0;
	localparam logic [2:0] PTD_CUST_SUB_BAD2 = 3'h2;
	localparam logic [2:0] PTD_CUST_SUB_BAD3 = 3'h3;
	localparam logic [2:0] PTD_CUST_SUB_BAD4 = 3'h4;
	localparam logic [2:0] PTD_CUST_SUB_BAD6 = 3'h6;
	localparam logic [3:0] PTD_LOAD_CUSTOM_REG_OP = 4'h2;
	localparam logic [3:0] PTD_STORE_CUSTOM_REG_OP = 4'h3;

	typedef enum logic [1:0] {PTD_FMT_OTHER = 2'h0, PTD_FMT_MMU = 2'h1, PTD_FMT_CUSTOM = 2'h2} ptd_fmt_t;

	typedef enum logic [2:0] {
		PTD_MODE_NONE = 3'h0, PTD_MODE_REG = 3'h1, PTD_MODE_IMM = 3'h2, PTD_MODE_MEM = 3'h3,
		PTD_MODE_MEMREL = 3'h4, PTD_MODE_EXT = 3'h5, PTD_MODE_TOS = 3'h6
	} ptd_mode_t;

	// Gray codes along idle, run, done; the wait state hangs off idle
	typedef enum logic [1:0] {PTD_AU_IDLE = 2'h0, PTD_AU_WAIT_EU = 2'h2, PTD_AU_RUN = 2'h1, PTD_AU_DONE = 2'h3} ptd_au_st_t;

	typedef struct packed {
		ptd_fmt_t fmt;
		logic [2:0] sub;
		logic [3:0] op;
	} ptd_dec_t;

	typedef struct packed {
		logic dword;
		logic odd_addr;
		logic dfp_imm;
		logic last;
	} ptd_fld_t;

	// Width codes: 00 byte, 01 word, 11 double word
	typedef struct packed {
		logic serialize;
		logic nonpipe;
		logic [1:0] quad_mem;
		ptd_mode_t gen1;
		logic gen1_scaled;
		ptd_mode_t gen2;
		logic gen2_scaled;
		logic [3:0] listed_extra;
		logic base_use;
		logic [3:0] base_reg;
		logic idx_use;
		logic [3:0] idx_reg;
		logic src_use;
		logic [3:0] src_reg;
		logic [1:0] src_width;
		logic dst_use;
		logic [3:0] dst_reg;
		logic [1:0] dst_width;
		logic dst_by_tos;
		ptd_cnt_t exe_cycles;
	} ptd_instr_t;

	typedef struct packed {
		logic vld;
		logic [3:0] rnum;
		logic [1:0] width;
		logic by_tos;
		logic ser;
	} ptd_wr_t;

	localparam ptd_wr_t PTD_WR_RESET = '0;
endpackage
`default_nettype wire

// ### tb/tb_ptd_core.sv
// Self-checking bench for the pipeline timing and undefined-instruction decode block
`default_nettype none
module tb_ptd_core;
	timeunit 1ns;
	timeprecision 1ns;
	import ptd_pkg::*;

	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic dec_valid = 1'b0;
	logic fld_valid = 1'b0;
	logic au_valid = 1'b0;
	ptd_dec_t dec_in = '0;
	ptd_fld_t fld_in = '0;
	ptd_instr_t au_in = '0;
	logic fld_ready;
	logic au_ready;
	logic undefined_instruction_trap;
	logic pipe_advance;
	logic eu_busy;
	logic au_stalling;
	int bad_count = 0;
	int num_checks = 0;
	int stall_seen = 0;
	// The advance takes one edge after the address unit is done
	localparam int ADV_LAT = 1;

	always #10 clk_sys = ~clk_sys;

	ptd_core uut (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.dec_valid(dec_valid),
		.dec_in(dec_in),
		.fld_valid(fld_valid),
		.fld_in(fld_in),
		.fld_ready(fld_ready),
		.au_valid(au_valid),
		.au_in(au_in),
		.au_ready(au_ready),
		.undefined_instruction_trap(undefined_instruction_trap),
		.pipe_advance(pipe_advance),
		.eu_busy(eu_busy),
		.au_stalling(au_stalling)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		num_checks++;
		if (got != exp) begin
			bad_count++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return fld_ready;
			1: return au_ready;
			default: return pipe_advance;
		endcase
	endfunction

	// Counts negedges until the chosen output is high; a hang ends the run
	task automatic wait_hi(input int w, output int n);
		n = 0;
		while (sig(w) !== 1'b1) begin
			if (au_stalling === 1'b1) stall_seen++;
			@(negedge clk_sys);
			n++;
			if (n > 300) begin
				bad_count++;
				$display("wrong value wait expected done seen hang");
				conclude();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic dec_one(input ptd_fmt_t f, input logic [2:0] s, input logic [3:0] o, input logic exp);
		dec_valid = 1'b1;
		dec_in = '{f, s, o};
		@(negedge clk_sys);
		chk_bit("trap", exp, undefined_instruction_trap);
	endtask

	task automatic test_decode();
		logic bad;
		for (int i = 0; i < 16; i++) begin
			bad = !(4'(i) inside {PTD_READ_VALIDATE_OP, PTD_WRITE_VALIDATE_OP, PTD_LOAD_MGMT_REG_OP,
				PTD_STORE_MGMT_REG_OP, PTD_CACHE_INVALIDATE_OP});
			dec_one(PTD_FMT_MMU, 3'h0, 4'(i), bad);
		end
		for (int s = 0; s < 8; s++) begin
			for (int o = 0; o < 16; o++) begin
				if (3'(s) inside {PTD_CUST_SUB_BAD2, PTD_CUST_SUB_BAD3, PTD_CUST_SUB_BAD4, PTD_CUST_SUB_BAD6}) begin
					bad = 1'b1;
				end else if (3'(s) == PTD_CUST_SUB0) begin
					bad = !(4'(o) inside {PTD_LOAD_CUSTOM_REG_OP, PTD_STORE_CUSTOM_REG_OP});
				end else begin
					bad = 1'b0;
				end
				dec_one(PTD_FMT_CUSTOM, 3'(s), 4'(o), bad);
			end
		end
		dec_one(PTD_FMT_OTHER, 3'h2, 4'h8, 1'b0);
		dec_valid = 1'b0;
		@(negedge clk_sys);
		chk_bit("trap idle", 1'b0, undefined_instruction_trap);
		$display("test decode done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic fld_one(input logic [3:0] f, input int exp_busy);
		int n;
		fld_valid = 1'b1;
		fld_in = f;
		wait_hi(0, n);
		@(negedge clk_sys);
		fld_valid = 1'b0;
		wait_hi(0, n);
		chk_cnt("loader busy", exp_busy, n);
	endtask

	task automatic test_loader();
		// Bits: dword, odd_addr, dfp_imm, last
		fld_one(4'hC, 0);
		fld_one(4'hC, 1);
		fld_one(4'h1, 0);
		fld_one(4'hD, 0);
		fld_one(4'hC, 0);
		fld_one(4'h2, 1);
		$display("test loader done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	function automatic ptd_instr_t mk(input int extra, input int exe);
		ptd_instr_t i;
		i = '0;
		i.gen1 = PTD_MODE_REG;
		i.gen2 = PTD_MODE_REG;
		i.listed_extra = 4'(extra);
		i.exe_cycles = ptd_cnt_t'(exe);
		return i;
	endfunction

	// Latency is counted in edges from the taking edge to the advance pulse
	task automatic au_one(input ptd_instr_t ins, output int lat);
		int k;
		au_valid = 1'b1;
		au_in = ins;
		wait_hi(1, k);
		@(negedge clk_sys);
		au_valid = 1'b0;
		stall_seen = 0;
		wait_hi(2, lat);
		@(negedge clk_sys);
	endtask

	task automatic test_au_time();
		ptd_instr_t x;
		int lat;
		au_one(mk(0, 1), lat);
		chk_cnt("basic", 2 + ADV_LAT, lat);
		au_one(mk(3, 1), lat);
		chk_cnt("listed", 2 + 3 + ADV_LAT, lat);
		x = mk(0, 1);
		x.nonpipe = 1'b1;
		x.quad_mem = 2'h2;
		au_one(x, lat);
		chk_cnt("nonpipe", 2 + 3 + 4 + ADV_LAT, lat);
		x = mk(0, 1);
		x.gen1 = PTD_MODE_MEM;
		au_one(x, lat);
		chk_cnt("one mem", 2 + ADV_LAT, lat);
		x.gen2 = PTD_MODE_TOS;
		au_one(x, lat);
		chk_cnt("two mem", 2 + 2 + ADV_LAT, lat);
		x = mk(0, 1);
		x.gen1 = PTD_MODE_MEMREL;
		x.gen2_scaled = 1'b1;
		au_one(x, lat);
		chk_cnt("memrel scaled", 2 + 3 + 2 + ADV_LAT, lat);
		x.gen1 = PTD_MODE_EXT;
		x.gen2 = PTD_MODE_MEM;
		au_one(x, lat);
		chk_cnt("ext dual", 2 + 2 + 8 + 2 + ADV_LAT, lat);
		au_one(mk(0, 8), lat);
		chk_bit("eu busy", 1'b1, eu_busy);
		au_one(mk(0, 1), lat);
		chk_bit("eu bound", 1'b1, lat >= 6 && lat <= 9);
		chk_bit("eu idle", 1'b0, eu_busy);
		x = mk(0, 12);
		x.serialize = 1'b1;
		au_one(x, lat);
		au_one(mk(10, 1), lat);
		chk_bit("serial wait", 1'b1, lat >= 20 && lat <= 26);
		$display("test address unit done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Writer of register r, then a reader using r; the reader's delay and stall count are judged
	task automatic pair(input ptd_instr_t a, input ptd_instr_t b, input int gap, input int stall);
		int lat;
		au_one(a, lat);
		if (gap) au_one(mk(0, 1), lat);
		au_one(b, lat);
		chk_cnt("interlock delay", 2 + ADV_LAT + stall, lat);
		chk_cnt("stall cycles", stall, stall_seen);
	endtask

	function automatic ptd_instr_t wr(input int r, input int w, input int top_of_stack_mode, input int ser);
		ptd_instr_t i;
		i = mk(0, 0);
		i.dst_use = 1'b1;
		i.dst_reg = 4'(r);
		i.dst_width = 2'(w);
		i.dst_by_tos = 1'(top_of_stack_mode);
		i.serialize = 1'(ser);
		return i;
	endfunction

	function automatic ptd_instr_t rd(input int kind, input int r, input int w);
		ptd_instr_t i;
		i = mk(0, 1);
		i.base_use = (kind == 0);
		i.base_reg = 4'(r);
		i.idx_use = (kind == 1);
		i.idx_reg = 4'(r);
		i.src_use = (kind == 2);
		i.src_reg = 4'(r);
		i.src_width = 2'(w);
		return i;
	endfunction

	task automatic test_interlock();
		pair(wr(1, 3, 0, 0), rd(0, 1, 3), 0, 3);
		pair(wr(2, 3, 0, 0), rd(0, 2, 3), 1, 1);
		pair(wr(4, 3, 0, 0), rd(1, 4, 3), 0, 1);
		pair(wr(5, 3, 0, 0), rd(1, 5, 3), 1, 0);
		pair(wr(6, 0, 0, 0), rd(2, 6, 3), 0, 2);
		pair(wr(7, 3, 0, 0), rd(2, 7, 3), 0, 0);
		pair(wr(8, 3, 1, 0), rd(0, 8, 3), 0, 0);
		pair(wr(9, 3, 0, 1), rd(0, 9, 3), 0, 0);
		$display("test interlock done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_bit("reset fld_ready", 1'b1, fld_ready);
		chk_bit("reset au_ready", 1'b1, au_ready);
		chk_bit("reset advance", 1'b0, pipe_advance);
		chk_bit("reset stalling", 1'b0, au_stalling);
		arst_n = 1'b1;
		@(negedge clk_sys);
		test_decode();
		test_loader();
		test_au_time();
		test_interlock();
		conclude();
	end
endmodule
`default_nettype wire

// ### verilog/ptd_core.sv
// Pipeline timing, interlock and undefined-instruction decode for the four-stage pipeline
`default_nettype none
module ptd_core (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic dec_valid,
	input wire ptd_pkg::ptd_dec_t dec_in,
	input wire logic fld_valid,
	input wire ptd_pkg::ptd_fld_t fld_in,
	output logic fld_ready,
	input wire logic au_valid,
	input wire ptd_pkg::ptd_instr_t au_in,
	output logic au_ready,
	output logic undefined_instruction_trap,
	output logic pipe_advance,
	output logic eu_busy,
	output logic au_stalling
);
	import ptd_pkg::*;

	typedef struct packed {
		logic [1:0] ld_cnt;
		logic ld_prev_odd_dw;
		logic trap;
		ptd_au_st_t au_st;
		ptd_instr_t au_ins;
		ptd_cnt_t au_cnt;
		ptd_cnt_t stall;
		logic eu_vld;
		logic eu_ser;
		ptd_cnt_t eu_cnt;
		ptd_wr_t h1;
		ptd_wr_t h2;
		logic adv;
	} ptd_state_t;

	ptd_state_t s_r;
	ptd_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic ptd_undef(input ptd_dec_t d);
		logic bad;
		bad = 1'b0;
		case (d.fmt)
			PTD_FMT_MMU: begin
				bad = !(d.op == PTD_READ_VALIDATE_OP || d.op == PTD_WRITE_VALIDATE_OP ||
					d.op == PTD_LOAD_MGMT_REG_OP || d.op == PTD_STORE_MGMT_REG_OP ||
					d.op == PTD_CACHE_INVALIDATE_OP);
			end
			PTD_FMT_CUSTOM: begin
				if (d.sub == PTD_CUST_SUB_BAD2 || d.sub == PTD_CUST_SUB_BAD3 ||
					d.sub == PTD_CUST_SUB_BAD4 || d.sub == PTD_CUST_SUB_BAD6) begin
					bad = 1'b1;
				end else if (d.sub == PTD_CUST_SUB0) begin
					bad = !(d.op == PTD_LOAD_CUSTOM_REG_OP || d.op == PTD_STORE_CUSTOM_REG_OP);
				end
			end
			default: bad = 1'b0;
		endcase
		return bad;
	endfunction

	function automatic logic ptd_is_mem(input ptd_mode_t m);
		return m == PTD_MODE_MEM || m == PTD_MODE_MEMREL || m == PTD_MODE_EXT || m == PTD_MODE_TOS;
	endfunction

	function automatic ptd_cnt_t ptd_mode_extra(input ptd_mode_t m, input logic scaled);
		ptd_cnt_t c;
		c = '0;
		case (m)
			PTD_MODE_MEMREL: c = PTD_AU_MEMREL_CYC;
			PTD_MODE_EXT: c = PTD_AU_EXT_CYC;
			default: c = '0;
		endcase
		if (scaled) begin
			c = c + PTD_AU_SCALED_CYC;
		end
		return c;
	endfunction

	// Writers that cannot interlock: no write, implicit stack move, or a serializing writer
	function automatic logic ptd_wr_hits(input ptd_wr_t w, input logic use_r, input logic [3:0] rn);
		return w.vld && use_r && !w.by_tos && !w.ser && w.rnum == rn;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Combinational terms

	logic [1:0] ld_cyc;
	logic ld_odd_dw;
	logic fld_take;
	ptd_cnt_t au_time;
	ptd_cnt_t stall_calc;
	logic adv_c;
	logic au_load;
	ptd_wr_t w1;
	ptd_wr_t w2;
	ptd_wr_t au_wr;
	logic base_hit1;
	logic base_hit2;
	logic idx_hit1;
	logic src_hit1;

	always_comb begin
		ld_odd_dw = fld_in.dword && fld_in.odd_addr;
		ld_cyc = fld_in.dfp_imm ? PTD_LD_DFP_CYC : PTD_LD_FIELD_CYC;
		if (ld_odd_dw && s_r.ld_prev_odd_dw && !fld_in.dfp_imm) begin
			ld_cyc = ld_cyc + PTD_LD_ODD_DW_EXTRA;
		end
	end

	assign fld_ready = (s_r.ld_cnt == 2'h0);
	assign fld_take = fld_valid && fld_ready;

	always_comb begin
		au_time = PTD_AU_BASE_CYC + PTD_CNT_W'(au_in.listed_extra);
		if (au_in.nonpipe) begin
			au_time = au_time + PTD_AU_NONPIPE_CYC +
				PTD_CNT_W'(au_in.quad_mem) * PTD_AU_QUAD_MEM_CYC;
		end
		if (au_in.gen2 != PTD_MODE_NONE && ptd_is_mem(au_in.gen1) && ptd_is_mem(au_in.gen2)) begin
			au_time = au_time + PTD_AU_DUAL_MEM_CYC;
		end
		au_time = au_time + ptd_mode_extra(au_in.gen1, au_in.gen1_scaled) +
			ptd_mode_extra(au_in.gen2, au_in.gen2_scaled);
	end

	// Advance needs both the address unit result and a free execution unit
	assign adv_c = (s_r.au_st == PTD_AU_DONE) && (s_r.eu_cnt == '0);
	assign au_ready = (s_r.au_st == PTD_AU_IDLE) || adv_c;
	assign au_load = au_valid && au_ready;

	always_comb begin
		au_wr.vld = s_r.au_ins.dst_use;
		au_wr.rnum = s_r.au_ins.dst_reg;
		au_wr.width = s_r.au_ins.dst_width;
		au_wr.by_tos = s_r.au_ins.dst_by_tos;
		au_wr.ser = s_r.au_ins.serialize;
		// On an advance the instruction leaving the address unit becomes the nearest writer
		w1 = adv_c ? au_wr : s_r.h1;
		w2 = adv_c ? s_r.h1 : s_r.h2;
		base_hit1 = ptd_wr_hits(w1, au_in.base_use, au_in.base_reg);
		base_hit2 = ptd_wr_hits(w2, au_in.base_use, au_in.base_reg);
		idx_hit1 = ptd_wr_hits(w1, au_in.idx_use, au_in.idx_reg);
		// Bypass covers equal or narrower sources; a wider read must wait for the full register
		src_hit1 = ptd_wr_hits(w1, au_in.src_use, au_in.src_reg) && (au_in.src_width > w1.width);
		stall_calc = '0;
		if (base_hit1) begin
			stall_calc = PTD_BASE_STALL_N1;
		end else if (src_hit1) begin
			stall_calc = PTD_WIDE_SRC_STALL;
		end else begin
			// Stalls do not add up: the longer of the two applies
			if (base_hit2) begin
				stall_calc = PTD_BASE_STALL_N2;
			end
			if (idx_hit1 && PTD_IDX_STALL_N1 > stall_calc) begin
				stall_calc = PTD_IDX_STALL_N1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.adv = adv_c;
		s_nxt.trap = dec_valid && ptd_undef(dec_in);

		if (s_r.ld_cnt != 2'h0) begin
			s_nxt.ld_cnt = s_r.ld_cnt - 2'h1;
		end
		if (fld_take) begin
			s_nxt.ld_cnt = ld_cyc - 2'h1;
			s_nxt.ld_prev_odd_dw = ld_odd_dw && !fld_in.last;
		end

		if (s_r.eu_cnt != '0) begin
			s_nxt.eu_cnt = s_r.eu_cnt - 8'h01;
		end

		case (s_r.au_st)
			PTD_AU_WAIT_EU: begin
				if (s_r.eu_cnt == '0) begin
					s_nxt.au_st = PTD_AU_RUN;
				end
			end
			PTD_AU_RUN: begin
				// Stall is spent before the processing time so that the two add up
				if (s_r.stall != '0) begin
					s_nxt.stall = s_r.stall - 8'h01;
				end else if (s_r.au_cnt != '0) begin
					s_nxt.au_cnt = s_r.au_cnt - 8'h01;
				end
				if ((s_r.stall == '0 && s_r.au_cnt <= 8'h01) || (s_r.stall == 8'h01 && s_r.au_cnt == '0)) begin
					s_nxt.au_st = PTD_AU_DONE;
				end
			end
			PTD_AU_DONE: begin
				if (adv_c) begin
					s_nxt.au_st = PTD_AU_IDLE;
				end
			end
			default: s_nxt.au_st = s_r.au_st;
		endcase

		if (adv_c) begin
			s_nxt.eu_vld = 1'b1;
			s_nxt.eu_ser = s_r.au_ins.serialize;
			s_nxt.eu_cnt = s_r.au_ins.exe_cycles;
			s_nxt.h1 = au_wr;
			s_nxt.h2 = s_r.h1;
		end else if (s_r.eu_cnt == 8'h01 || s_r.eu_cnt == '0) begin
			s_nxt.eu_vld = 1'b0;
		end

		if (au_load) begin
			s_nxt.au_ins = au_in;
			s_nxt.au_cnt = au_time;
			s_nxt.stall = stall_calc;
			// A serializing instruction in, or entering, the execution unit holds the address unit
			if ((adv_c && s_r.au_ins.serialize && s_r.au_ins.exe_cycles != '0) ||
				(!adv_c && s_r.eu_ser && s_r.eu_cnt != '0)) begin
				s_nxt.au_st = PTD_AU_WAIT_EU;
			end else begin
				s_nxt.au_st = PTD_AU_RUN;
			end
		end
		if (s_nxt.eu_cnt == '0 && !adv_c) begin
			s_nxt.eu_ser = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '{ld_cnt: 2'h0, ld_prev_odd_dw: 1'b0, trap: 1'b0, au_st: PTD_AU_IDLE, au_ins: '0,
				au_cnt: '0, stall: '0, eu_vld: 1'b0, eu_ser: 1'b0, eu_cnt: '0,
				h1: PTD_WR_RESET, h2: PTD_WR_RESET, adv: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign undefined_instruction_trap = s_r.trap;
	assign pipe_advance = s_r.adv;
	assign eu_busy = s_r.eu_vld;
	assign au_stalling = (s_r.au_st == PTD_AU_RUN) && (s_r.stall != '0);

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_mmu_trap;
		@(posedge clk_sys) disable iff (!arst_n)
		(dec_valid && dec_in.fmt == PTD_FMT_MMU && (dec_in.op[3:2] == 2'h1 || dec_in.op == 4'h8 ||
			dec_in.op[3:1] == 3'h5 || dec_in.op[3:2] == 2'h3)) |=> undefined_instruction_trap;
	endproperty
	a_mmu_trap: assert property (p_mmu_trap) else $error("mmu code did not trap");

	property p_cust_sub_trap;
		@(posedge clk_sys) disable iff (!arst_n)
		(dec_valid && dec_in.fmt == PTD_FMT_CUSTOM && (dec_in.sub == 3'h2 || dec_in.sub == 3'h3 ||
			dec_in.sub == 3'h4 || dec_in.sub == 3'h6)) |=> undefined_instruction_trap;
	endproperty
	a_cust_sub_trap: assert property (p_cust_sub_trap) else $error("custom sub-format did not trap");

	property p_cust0;
		@(posedge clk_sys) disable iff (!arst_n)
		(dec_valid && dec_in.fmt == PTD_FMT_CUSTOM && dec_in.sub == 3'h0)
			|=> (undefined_instruction_trap == !($past(dec_in.op) == 4'h2 || $past(dec_in.op) == 4'h3));
	endproperty
	a_cust0: assert property (p_cust0) else $error("custom sub-format zero decode wrong");

	property p_adv_cond;
		@(posedge clk_sys) disable iff (!arst_n)
		pipe_advance |-> $past(s_r.eu_cnt) == '0 && $past(s_r.au_cnt) == '0 && $past(s_r.stall) == '0;
	endproperty
	a_adv_cond: assert property (p_adv_cond) else $error("advance before both units finished");

	property p_ser_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_r.au_st == PTD_AU_WAIT_EU && s_r.eu_cnt != '0) |=> $stable(s_r.au_cnt) && s_r.au_st != PTD_AU_DONE;
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("address unit ran during serializing wait");

	property p_ld_single;
		@(posedge clk_sys) disable iff (!arst_n)
		(fld_take && !fld_in.dfp_imm && !fld_in.dword) |=> fld_ready;
	endproperty
	a_ld_single: assert property (p_ld_single) else $error("plain field took more than one cycle");

	sequence s_ld_two;
		!fld_ready ##1 fld_ready;
	endsequence
	property p_ld_dfp;
		@(posedge clk_sys) disable iff (!arst_n)
		(fld_take && fld_in.dfp_imm) |=> s_ld_two;
	endproperty
	a_ld_dfp: assert property (p_ld_dfp) else $error("double float immediate not two cycles");

	property p_odd_dw;
		@(posedge clk_sys) disable iff (!arst_n)
		(fld_take && fld_in.dword && fld_in.odd_addr && !fld_in.dfp_imm && s_r.ld_prev_odd_dw) |=> s_ld_two;
	endproperty
	a_odd_dw: assert property (p_odd_dw) else $error("odd double-word pair missed extra cycle");

	sequence s_stall_three;
		(au_stalling && s_r.stall == 8'h03) ##1 au_stalling [*2] ##1 !au_stalling;
	endsequence
	property p_base_stall;
		@(posedge clk_sys) disable iff (!arst_n)
		(au_load && base_hit1) |=> s_stall_three;
	endproperty
	a_base_stall: assert property (p_base_stall) else $error("base interlock stall not three cycles");

	property p_au_basic;
		@(posedge clk_sys) disable iff (!arst_n)
		(au_load && au_in.listed_extra == 4'h0 && !au_in.nonpipe && au_in.gen1 == PTD_MODE_REG &&
			!au_in.gen1_scaled && (au_in.gen2 == PTD_MODE_NONE || au_in.gen2 == PTD_MODE_REG) &&
			!au_in.gen2_scaled) |=> s_r.au_cnt == 8'h02;
	endproperty
	a_au_basic: assert property (p_au_basic) else $error("basic address unit time not two");
endmodule
`default_nettype wire
